// [bench/msm_prog_model.sv]
`timescale 1ns/1ns
module msm_prog_model (
    input  logic               mclk_i,
    input  logic [7:0]         prg_rdata_i,
    input  logic               prg_rvalid_i,
    input  logic               prg_refused_i,
    input  logic               erase_busy_i,
    output msm_pkg::msm_preq_t preq_o
);
    initial preq_o = '0;
    // One-cycle request; kinds are {rd, wr, protect, erase}, on release kind is zero and address and data show the inverse
    task automatic req(input logic [3:0] k, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        preq_o = {k, a, d};
        @(posedge mclk_i);
        #1;
        preq_o = {4'h0, ~a, ~d};
    endtask : req
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic rf);
        int i;
        req(4'h8, a, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            if (prg_rvalid_i === 1'b1 || prg_refused_i === 1'b1)
                break;
            @(posedge mclk_i);
            #1;
        end
        d = prg_rdata_i;
        rf = prg_refused_i;
    endtask : rd
    // Counts the cycles the erase sweep keeps busy high
    task automatic erase(output int n);
        req(4'h1, 12'h000, 8'h00);
        n = 0;
        while (erase_busy_i === 1'b1 && n < 5000)
        begin
            n++;
            @(posedge mclk_i);
            #1;
        end
    endtask : erase
endmodule : msm_prog_model

// [bench/testbench.sv]
`timescale 1ns/1ns
`define TB_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic               mclk_i, rst_i, nmi_n_i, reset_n_i, vpp_high_i, ro_opt;
    logic [23:0]        port_pin_i, p_out, p_oe_n, p_pu;
    msm_pkg::msm_dreq_t dreq;
    msm_pkg::msm_preq_t preq;
    logic [3:0]         pcop;
    logic [11:0]        pc_tgt, pc_o;
    logic [7:0]         fetch, rdata, prg_rdata;
    logic               rvalid, nmi_req, core_rst, prog_mode, prot, busy, prg_rv, prg_rf;
    int                 errors, n_tests;

    msm_space_map u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .nmi_n_i(nmi_n_i),
        .reset_n_i(reset_n_i), .vpp_high_i(vpp_high_i), .ro_option_i(ro_opt),
        .port_pin_i(port_pin_i), .dreq_i(dreq), .preq_i(preq), .pc_inc_i(pcop[0]),
        .pc_load_i(pcop[1]), .pc_call_i(pcop[2]), .pc_ret_i(pcop[3]), .pc_target_i(pc_tgt),
        .pc_o(pc_o), .fetch_data_o(fetch), .data_rdata_o(rdata), .data_rvalid_o(rvalid),
        .nmi_req_o(nmi_req), .core_reset_o(core_rst), .prog_mode_o(prog_mode),
        .protected_o(prot), .erase_busy_o(busy), .prg_rdata_o(prg_rdata),
        .prg_rvalid_o(prg_rv), .prg_refused_o(prg_rf), .port_out_o(p_out),
        .port_oe_n_o(p_oe_n), .pullup_input_o(p_pu));
    msm_prog_model u_prog (.mclk_i(mclk_i), .prg_rdata_i(prg_rdata), .prg_rvalid_i(prg_rv),
        .prg_refused_i(prg_rf), .erase_busy_i(busy), .preq_o(preq));

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic dacc(input logic w, input logic [7:0] a, input logic [7:0] d);
        dreq = {~w, w, a, d};
        cyc(1);
        dreq = {2'b00, ~a, ~d};
        cyc(1);
    endtask : dacc
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        dacc(1'b0, a, 8'h00);
        `TB_CHK("rvalid", 1'b1, rvalid)
        `TB_CHK("rdata", e, rdata)
    endtask : rdchk
    task automatic pc(input logic [3:0] k, input logic [11:0] t);
        pcop = k;
        pc_tgt = t;
        cyc(1);
        pcop = 4'h0;
        pc_tgt = ~t;
        cyc(1);
    endtask : pc
    task automatic nmi_watch(input int n, output logic seen);
        seen = 1'b0;
        repeat (n)
        begin
            cyc(1);
            seen = seen | (nmi_req === 1'b1);
        end
    endtask : nmi_watch
    task automatic t_reset();
        logic seen;
        `TB_CHK("prog_mode", 1'b1, prog_mode)
        `TB_CHK("core_reset", 1'b1, core_rst)
        `TB_CHK("pullup", 24'hFFFFFF, p_pu)
        `TB_CHK("oe_n", 24'hFFFFFF, p_oe_n)
        nmi_n_i = 1'b0;
        nmi_watch(8, seen);
        `TB_CHK("nmi_in_reset", 1'b0, seen)
        nmi_n_i = 1'b1;
        cyc(4);
    endtask : t_reset
    task automatic t_prog();
        logic [7:0] d;
        logic       rf;
        int         n;
        u_prog.req(4'h4, 12'h045, 8'h5A);
        u_prog.rd(12'h045, d, rf);
        `TB_CHK("prg_rd", 8'h5A, d)
        u_prog.req(4'h2, 12'h000, 8'h00);
        `TB_CHK("prot_set", 1'b1, prot)
        u_prog.rd(12'h045, d, rf);
        `TB_CHK("prg_refused", 1'b1, rf)
        `TB_CHK("prg_rd_prot", 8'h00, d)
        u_prog.erase(n);
        `TB_CHK("erase_len", 4096, n)
        `TB_CHK("prot_clr", 1'b0, prot)
        u_prog.rd(12'h045, d, rf);
        `TB_CHK("erased", 8'hFF, d)
        u_prog.req(4'h4, 12'h045, 8'h5A);
        u_prog.req(4'h4, 12'hFC5, 8'h3C);
        u_prog.req(4'h4, 12'hFFF, 8'hA5);
    endtask : t_prog
    task automatic t_exit();
        vpp_high_i = 1'b0;
        cyc(4);
        `TB_CHK("prog_exit", 1'b0, prog_mode)
        reset_n_i = 1'b1;
        cyc(2);
        `TB_CHK("core_rst_hold", 1'b1, core_rst)
        cyc(2);
        `TB_CHK("core_rst_off", 1'b0, core_rst)
    endtask : t_exit
    task automatic t_window();
        dacc(1'b1, 8'hC9, 8'h01);
        rdchk(8'h45, 8'h5A);
        dacc(1'b1, 8'hC9, 8'h3F);
        rdchk(8'h45, 8'h3C);
        rdchk(8'h7F, 8'hA5);
        dacc(1'b1, 8'h45, 8'h00);
        rdchk(8'h45, 8'h3C);
        rdchk(8'hC9, 8'h00);
        dacc(1'b1, 8'h05, 8'h77);
        rdchk(8'h05, 8'h77);
        rdchk(8'h45, 8'h3C);
        dacc(1'b1, 8'hFF, 8'h99);
        rdchk(8'hFF, 8'h99);
        dacc(1'b1, 8'h81, 8'h12);
        rdchk(8'h81, 8'h12);
        rdchk(8'h84, 8'h00);
    endtask : t_window
    task automatic t_ports();
        dacc(1'b1, 8'hC4, 8'h0F);
        dacc(1'b1, 8'hC0, 8'h55);
        `TB_CHK("oe_n", 8'hF0, p_oe_n[7:0])
        `TB_CHK("pullup", 8'hF0, p_pu[7:0])
        `TB_CHK("pullup_bc", 16'hFFFF, p_pu[23:8])
        `TB_CHK("port_out", 8'h55, p_out[7:0])
        rdchk(8'hC0, 8'hA5);
        dacc(1'b1, 8'hCC, 8'h10);
        `TB_CHK("pullup_opt", 8'hE0, p_pu[7:0])
    endtask : t_ports
    task automatic t_pc();
        int i;
        pc(4'h2, 12'hFFF);
        `TB_CHK("pc_load", 12'hFFF, pc_o)
        cyc(3);
        `TB_CHK("fetch", 8'hA5, fetch)
        pc(4'h1, 12'h000);
        `TB_CHK("pc_wrap", 12'h000, pc_o)
        for (i = 0; i < 6; i++)
            pc(4'h4, 12'h100 + i[11:0]);
        `TB_CHK("pc_call", 12'h105, pc_o)
        for (i = 0; i < 6; i++)
            pc(4'h8, 12'h000);
        `TB_CHK("pc_ret6", 12'h001, pc_o)
    endtask : t_pc
    task automatic t_nmi();
        logic seen;
        nmi_n_i = 1'b0;
        nmi_watch(6, seen);
        `TB_CHK("nmi_fall", 1'b1, seen)
        nmi_n_i = 1'b1;
        nmi_watch(8, seen);
        `TB_CHK("nmi_rise", 1'b0, seen)
    endtask : t_nmi
    // Second reset with the protection option set; window select must survive it
    task automatic t_strap();
        ro_opt = 1'b1;
        rst_i = 1'b1;
        cyc(2);
        `TB_CHK("prot_in_rst", 1'b0, prot)
        rst_i = 1'b0;
        cyc(2);
        `TB_CHK("prot_strap", 1'b1, prot)
        `TB_CHK("core_rst_rel", 1'b1, core_rst)
        rdchk(8'h45, 8'h3C);
    endtask : t_strap

    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial
    begin
        errors = 0;
        n_tests = 0;
        rst_i = 1'b1;
        nmi_n_i = 1'b1;
        reset_n_i = 1'b0;
        vpp_high_i = 1'b1;
        ro_opt = 1'b0;
        port_pin_i = 24'hA5A5A5;
        dreq = '0;
        pcop = 4'h0;
        pc_tgt = 12'h000;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        cyc(4);
        t_reset();
        t_prog();
        t_exit();
        t_window();
        t_ports();
        t_pc();
        t_nmi();
        t_strap();
        close_out();
    end
    initial
    begin
        #(20000 * 100);
        errors++;
        close_out();
    end
endmodule : testbench

// [src/msm_map.svh]
`ifndef MSM_MAP_SVH
`define MSM_MAP_SVH
`define MSM_PC_W      12
`define MSM_DW        8
`define MSM_OFS_W     6
`define MSM_STACK_D   6
`define MSM_PORTS     3
`define MSM_IDX_IW    2
`define MSM_RAM_AW    6
`define MSM_RAM_HI    8'h3F
`define MSM_WIN_LO    8'h40
`define MSM_WIN_HI    8'h7F
`define MSM_IDX_LO    8'h80
`define MSM_IDX_HI    8'h83
`define MSM_DR_LO     8'hC0
`define MSM_DR_HI     8'hC2
`define MSM_DDR_LO    8'hC4
`define MSM_DDR_HI    8'hC6
`define MSM_IOR       8'hC8
`define MSM_WSEL      8'hC9
`define MSM_OR_LO     8'hCC
`define MSM_OR_HI     8'hCE
`define MSM_ACC       8'hFF
`define MSM_RST_BYTE  8'h00
`define MSM_ONES_BYTE 8'hFF
`define MSM_ERASED    8'hFF
`define MSM_RST_PC    12'h000
`define MSM_PC_STEP   12'h001
`define MSM_PM_LAST   12'hFFF
`define MSM_PM_SIZE   13'h1000
`endif

// [src/msm_mem.sv]
`timescale 1ns/1ns
module msm_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  logic          mclk_i,
    input  logic [AW-1:0] a_addr_i,
    output logic [DW-1:0] a_rdata_o,
    input  logic [AW-1:0] b_addr_i,
    output logic [DW-1:0] b_rdata_o,
    input  logic          we_i,
    input  logic [AW-1:0] waddr_i,
    input  logic [DW-1:0] wdata_i
);
    initial begin
        if (AW < 1 || DW < 1)
        begin
            $error("msm_mem: bad geometry");
        end
    end

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        a_rdata_o <= mem[a_addr_i];
        b_rdata_o <= mem[b_addr_i];
    end
endmodule : msm_mem

// [src/msm_pkg.sv]
`include "msm_map.svh"
package msm_pkg;
    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [`MSM_DW-1:0]    addr;
        logic [`MSM_DW-1:0]    wdata;
    } msm_dreq_t;

    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic                  protect;
        logic                  erase;
        logic [`MSM_PC_W-1:0]  addr;
        logic [`MSM_DW-1:0]    wdata;
    } msm_preq_t;

    typedef enum logic [7:0] {
        RG_NONE = 8'h01,
        RG_RAM  = 8'h02,
        RG_WIN  = 8'h04,
        RG_IDX  = 8'h08,
        RG_PORT = 8'h10,
        RG_IOR  = 8'h20,
        RG_WSEL = 8'h40,
        RG_ACC  = 8'h80
    } msm_region_t;

    typedef enum logic [1:0] {
        ER_IDLE  = 2'h1,
        ER_SWEEP = 2'h2
    } msm_erase_t;
endpackage : msm_pkg

// [src/msm_space_map.sv]
// What this block does
// - Program, data and stack spaces are decoded separately from each other.
// - A twelve-bit program counter reaches 4K bytes of program memory.
// - Six-entry hardware return stack holds call and interrupt return addresses.
// - Program memory holds code, immediates, factory test area and vectors.
// - Data reads reach program memory constants through a 64-byte read-only window.
// - Data space decodes RAM, accumulator, index, short direct, port, option, window registers.
// - With readout protection set, external program memory reads are refused.
// - Only an erase or a reset with the protection option clear clears protection; an erase erases all program memory.
// - A falling edge on the interrupt pin raises the non-maskable interrupt.
// - Reset pin is active low and beats every interrupt, NMI included.
// - After reset every port pin is an input with pull-up until reconfigured.
// - Programming voltage high during reset enters programming mode; ground is normal.
// - Window spans data 0x40 to 0x7F, showing one aligned 64-byte block of program bytes.
// - Window select picks the block and is not cleared by reset.
`timescale 1ns/1ns
module msm_space_map #(
    parameter int STACK_D = `MSM_STACK_D,
    parameter int PORTS   = `MSM_PORTS
) (
    input  logic                   mclk_i,
    input  logic                   rst_i,
    input  logic                   nmi_n_i,
    input  logic                   reset_n_i,
    input  logic                   vpp_high_i,
    input  logic                   ro_option_i,
    input  logic [PORTS*8-1:0]     port_pin_i,
    input  msm_pkg::msm_dreq_t     dreq_i,
    input  msm_pkg::msm_preq_t     preq_i,
    input  logic                   pc_inc_i,
    input  logic                   pc_load_i,
    input  logic                   pc_call_i,
    input  logic                   pc_ret_i,
    input  logic [`MSM_PC_W-1:0]   pc_target_i,
    output logic [`MSM_PC_W-1:0]   pc_o,
    output logic [`MSM_DW-1:0]     fetch_data_o,
    output logic [`MSM_DW-1:0]     data_rdata_o,
    output logic                   data_rvalid_o,
    output logic                   nmi_req_o,
    output logic                   core_reset_o,
    output logic                   prog_mode_o,
    output logic                   protected_o,
    output logic                   erase_busy_o,
    output logic [`MSM_DW-1:0]     prg_rdata_o,
    output logic                   prg_rvalid_o,
    output logic                   prg_refused_o,
    output logic [PORTS*8-1:0]     port_out_o,
    output logic [PORTS*8-1:0]     port_oe_n_o,
    output logic [PORTS*8-1:0]     pullup_input_o
);
    initial begin
        if (STACK_D < 1 || PORTS < 1 || PORTS > 3)
        begin
            $error("msm_space_map: unsupported stack depth or port count");
        end
    end

    // Pin synchronisers
    logic nmi_s1, nmi_s2, nmi_s3, rst_s1, rst_s2, vpp_s1, vpp_s2;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {nmi_s1, nmi_s2, nmi_s3} <= 3'h7;
            {rst_s1, rst_s2}         <= 2'h0;
            {vpp_s1, vpp_s2}         <= 2'h0;
        end
        else
        begin
            {nmi_s1, nmi_s2, nmi_s3} <= {nmi_n_i, nmi_s1, nmi_s2};
            {rst_s1, rst_s2}         <= {reset_n_i, rst_s1};
            {vpp_s1, vpp_s2}         <= {vpp_high_i, vpp_s1};
        end
    end

    wire nmi_fall  = nmi_s3 & ~nmi_s2;
    wire nmi_next  = nmi_fall & rst_s2;
    logic prog_mode_reg, strap_done_reg, prot_reg;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            nmi_req_o     <= 1'b0;
            core_reset_o  <= 1'b1;
            prog_mode_reg <= 1'b0;
        end
        else
        begin
            nmi_req_o    <= nmi_next;
            core_reset_o <= ~rst_s2;
            if (!rst_s2)
            begin
                prog_mode_reg <= vpp_s2;
            end
        end
    end
    assign prog_mode_o = prog_mode_reg;

    // Program memory erase sweep and readout protection
    msm_pkg::msm_erase_t er_state;
    logic [`MSM_PC_W-1:0] er_cnt;
    wire er_start = prog_mode_reg & preq_i.erase & (er_state == msm_pkg::ER_IDLE);
    wire er_done  = (er_state == msm_pkg::ER_SWEEP) & (er_cnt == `MSM_PM_LAST);
    wire prot_set = prog_mode_reg & preq_i.protect;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            er_state       <= msm_pkg::ER_IDLE;
            er_cnt         <= `MSM_RST_PC;
            prot_reg       <= 1'b0;
            strap_done_reg <= 1'b0;
        end
        else
        begin
            strap_done_reg <= 1'b1;
            unique case (er_state)
                msm_pkg::ER_IDLE:
                begin
                    er_cnt <= `MSM_RST_PC;
                    if (er_start)
                    begin
                        er_state <= msm_pkg::ER_SWEEP;
                    end
                end
                msm_pkg::ER_SWEEP:
                begin
                    er_cnt <= er_cnt + `MSM_PC_STEP;
                    if (er_done)
                    begin
                        er_state <= msm_pkg::ER_IDLE;
                    end
                end
                default:
                begin
                    er_state <= msm_pkg::ER_IDLE;
                end
            endcase
            if (!strap_done_reg)
            begin
                prot_reg <= ro_option_i;
            end
            else if (prot_set)
            begin
                prot_reg <= 1'b1;
            end
            else if (er_done)
            begin
                prot_reg <= 1'b0;
            end
        end
    end
    assign erase_busy_o = er_state[1];
    assign protected_o  = prot_reg;

    // Data space decode
    wire [`MSM_DW-1:0] da = dreq_i.addr;
    wire sel_dr  = (da >= `MSM_DR_LO) && (da <= `MSM_DR_HI);
    wire sel_ddr = (da >= `MSM_DDR_LO) && (da <= `MSM_DDR_HI);
    wire sel_or  = (da >= `MSM_OR_LO) && (da <= `MSM_OR_HI);
    wire in_win  = (da >= `MSM_WIN_LO) && (da <= `MSM_WIN_HI);
    wire in_idx  = (da >= `MSM_IDX_LO) && (da <= `MSM_IDX_HI);
    msm_pkg::msm_region_t region;
    assign region = (da <= `MSM_RAM_HI)    ? msm_pkg::RG_RAM  :
                    in_win                 ? msm_pkg::RG_WIN  :
                    in_idx                 ? msm_pkg::RG_IDX  :
                    (sel_dr | sel_ddr | sel_or) ? msm_pkg::RG_PORT :
                    (da == `MSM_IOR)       ? msm_pkg::RG_IOR  :
                    (da == `MSM_WSEL)      ? msm_pkg::RG_WSEL :
                    (da == `MSM_ACC)       ? msm_pkg::RG_ACC  : msm_pkg::RG_NONE;
    wire dwr = dreq_i.wr;

    logic [`MSM_DW-1:0] acc_reg, ior_reg;
    logic [`MSM_DW-1:0] idx_reg [0:3];
    logic [`MSM_OFS_W-1:0] wsel_reg;

    always_ff @(posedge mclk_i)
    begin
        if (dwr && region == msm_pkg::RG_WSEL)
        begin
            wsel_reg <= dreq_i.wdata[`MSM_OFS_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_reg <= `MSM_RST_BYTE;
            ior_reg <= `MSM_RST_BYTE;
            idx_reg <= '{default: `MSM_RST_BYTE};
        end
        else if (dwr)
        begin
            if (region == msm_pkg::RG_ACC)
            begin
                acc_reg <= dreq_i.wdata;
            end
            if (region == msm_pkg::RG_IOR)
            begin
                ior_reg <= dreq_i.wdata;
            end
            if (region == msm_pkg::RG_IDX)
            begin
                idx_reg[da[`MSM_IDX_IW-1:0]] <= dreq_i.wdata;
            end
        end
    end

    // Ports: data, direction and option per port
    logic [`MSM_DW-1:0] pdr [0:PORTS-1];
    logic [`MSM_DW-1:0] pddr [0:PORTS-1];
    logic [`MSM_DW-1:0] por [0:PORTS-1];
    logic [`MSM_DW-1:0] pval [0:PORTS-1];
    genvar k;
    generate
        for (k = 0; k < PORTS; k = k + 1)
        begin : g_port
            logic [`MSM_DW-1:0] ps1, ps2;
            wire hit = (da[1:0] == 2'(k)) & dwr;
            always_ff @(posedge mclk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    {pdr[k], pddr[k], por[k], ps1, ps2} <= '0;
                    port_out_o[k*8 +: 8]     <= `MSM_RST_BYTE;
                    port_oe_n_o[k*8 +: 8]    <= `MSM_ONES_BYTE;
                    pullup_input_o[k*8 +: 8] <= `MSM_ONES_BYTE;
                end
                else
                begin
                    {ps1, ps2} <= {port_pin_i[k*8 +: 8], ps1};
                    if (hit && sel_dr)
                        pdr[k] <= dreq_i.wdata;
                    if (hit && sel_ddr)
                        pddr[k] <= dreq_i.wdata;
                    if (hit && sel_or)
                        por[k] <= dreq_i.wdata;
                    port_out_o[k*8 +: 8]     <= pdr[k];
                    port_oe_n_o[k*8 +: 8]    <= ~pddr[k];
                    pullup_input_o[k*8 +: 8] <= ~pddr[k] & ~por[k];
                end
            end
            assign pval[k] = (pddr[k] & pdr[k]) | (~pddr[k] & ps2);
        end
    endgenerate

    // Memories
    logic [`MSM_PC_W-1:0] pc_reg;
    logic [`MSM_DW-1:0] pm_a_rdata, pm_b_rdata, ram_rdata;
    wire [`MSM_PC_W-1:0] pm_a_addr = prog_mode_reg ? preq_i.addr : pc_reg;
    wire [`MSM_PC_W-1:0] pm_b_addr = {wsel_reg, da[`MSM_OFS_W-1:0]};
    wire pm_we = erase_busy_o | (prog_mode_reg & preq_i.wr);
    wire [`MSM_PC_W-1:0] pm_waddr = erase_busy_o ? er_cnt : preq_i.addr;
    wire [`MSM_DW-1:0] pm_wdata = erase_busy_o ? `MSM_ERASED : preq_i.wdata;

    msm_mem #(.AW(`MSM_PC_W), .DW(`MSM_DW)) u_prog_mem (
        .mclk_i   (mclk_i),
        .a_addr_i (pm_a_addr),
        .a_rdata_o(pm_a_rdata),
        .b_addr_i (pm_b_addr),
        .b_rdata_o(pm_b_rdata),
        .we_i     (pm_we),
        .waddr_i  (pm_waddr),
        .wdata_i  (pm_wdata)
    );

    msm_mem #(.AW(`MSM_RAM_AW), .DW(`MSM_DW)) u_ram (
        .mclk_i   (mclk_i),
        .a_addr_i (da[`MSM_RAM_AW-1:0]),
        .a_rdata_o(ram_rdata),
        .b_addr_i ('0),
        .b_rdata_o(),
        .we_i     (dwr & (region == msm_pkg::RG_RAM)),
        .waddr_i  (da[`MSM_RAM_AW-1:0]),
        .wdata_i  (dreq_i.wdata)
    );

    // Data read pipeline and programmer read
    logic rd_q, prd_q, pref_q;
    logic [2:0] psel_q;
    logic [`MSM_DW-1:0] a_q;
    msm_pkg::msm_region_t reg_q;
    wire [`MSM_DW-1:0] pv = (a_q[1:0] < 2'(PORTS)) ? pval[a_q[1:0]] : `MSM_RST_BYTE;
    wire [`MSM_DW-1:0] pdd = (a_q[1:0] < 2'(PORTS)) ? pddr[a_q[1:0]] : `MSM_RST_BYTE;
    wire [`MSM_DW-1:0] pop = (a_q[1:0] < 2'(PORTS)) ? por[a_q[1:0]] : `MSM_RST_BYTE;
    wire [`MSM_DW-1:0] port_rd = psel_q[0] ? pv : psel_q[1] ? pdd : pop;
    wire [`MSM_DW-1:0] rd_mux =
        (reg_q == msm_pkg::RG_RAM)  ? ram_rdata :
        (reg_q == msm_pkg::RG_WIN)  ? pm_b_rdata :
        (reg_q == msm_pkg::RG_IDX)  ? idx_reg[a_q[`MSM_IDX_IW-1:0]] :
        (reg_q == msm_pkg::RG_PORT) ? port_rd :
        (reg_q == msm_pkg::RG_ACC)  ? acc_reg : `MSM_RST_BYTE;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {rd_q, prd_q, pref_q, psel_q} <= '0;
            a_q           <= `MSM_RST_BYTE;
            reg_q         <= msm_pkg::RG_NONE;
            data_rdata_o  <= `MSM_RST_BYTE;
            data_rvalid_o <= 1'b0;
            fetch_data_o  <= `MSM_RST_BYTE;
            prg_rdata_o   <= `MSM_RST_BYTE;
            prg_rvalid_o  <= 1'b0;
            prg_refused_o <= 1'b0;
        end
        else
        begin
            rd_q          <= dreq_i.rd;
            a_q           <= da;
            reg_q         <= region;
            psel_q        <= {sel_or, sel_ddr, sel_dr};
            data_rvalid_o <= rd_q;
            data_rdata_o  <= rd_q ? rd_mux : `MSM_RST_BYTE;
            fetch_data_o  <= pm_a_rdata;
            prd_q         <= prog_mode_reg & preq_i.rd & ~erase_busy_o;
            pref_q        <= prot_reg;
            prg_rvalid_o  <= prd_q;
            prg_refused_o <= prd_q & pref_q;
            prg_rdata_o   <= (prd_q & ~pref_q) ? pm_a_rdata : `MSM_RST_BYTE;
        end
    end

    // Program counter and return stack
    logic [`MSM_PC_W-1:0] stk [0:STACK_D-1];
    wire run = ~prog_mode_reg;
    wire do_ret  = run & pc_ret_i;
    wire do_call = run & pc_call_i & ~pc_ret_i;
    wire [`MSM_PC_W-1:0] pc_plus = pc_reg + `MSM_PC_STEP;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            pc_reg <= `MSM_RST_PC;
        else if (do_ret)
            pc_reg <= stk[0];
        else if (do_call || (run && pc_load_i))
            pc_reg <= pc_target_i;
        else if (run && pc_inc_i)
            pc_reg <= pc_plus;
    end
    assign pc_o = pc_reg;

    generate
        for (k = 0; k < STACK_D; k = k + 1)
        begin : g_stk
            wire [`MSM_PC_W-1:0] above = (k == 0) ? pc_plus : stk[(k == 0) ? 0 : k-1];
            wire [`MSM_PC_W-1:0] below = (k == STACK_D-1) ? stk[k] : stk[(k == STACK_D-1) ? k : k+1];
            always_ff @(posedge mclk_i or posedge rst_i)
            begin
                if (rst_i)
                    stk[k] <= `MSM_RST_PC;
                else if (do_call)
                    stk[k] <= above;
                else if (do_ret)
                    stk[k] <= below;
            end
        end
    endgenerate

    property p_win_addr;
        @(posedge mclk_i) disable iff (rst_i)
        (dreq_i.rd && in_win) |-> (pm_b_addr[`MSM_OFS_W-1:0] == da[`MSM_OFS_W-1:0])
            && (pm_b_addr[`MSM_PC_W-1:`MSM_OFS_W] == wsel_reg);
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("window address wrong");

    property p_win_ro;
        @(posedge mclk_i) disable iff (rst_i)
        (dreq_i.wr && region == msm_pkg::RG_WIN && !prog_mode_reg && !erase_busy_o) |-> !pm_we;
    endproperty
    a_win_ro: assert property (p_win_ro) else $error("window write reached memory");

    property p_win_lat;
        @(posedge mclk_i) disable iff (rst_i)
        (dreq_i.rd && in_win) |-> ##2 data_rvalid_o && (data_rdata_o == $past(pm_b_rdata));
    endproperty
    a_win_lat: assert property (p_win_lat) else $error("window read lost");

    property p_refuse;
        @(posedge mclk_i) disable iff (rst_i)
        (prog_mode_reg && preq_i.rd && !erase_busy_o && prot_reg) |->
            ##2 prg_refused_o && (prg_rdata_o == `MSM_RST_BYTE);
    endproperty
    a_refuse: assert property (p_refuse) else $error("protected read not refused");

    // Length of the current erase sweep, for the check below
    logic [`MSM_PC_W:0] er_len_reg;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            er_len_reg <= '0;
        else if (erase_busy_o)
            er_len_reg <= er_len_reg + 1'b1;
        else
            er_len_reg <= '0;
    end

    property p_erase;
        @(posedge mclk_i) disable iff (rst_i)
        er_start |=> erase_busy_o [*8];
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not start");

    property p_erase_end;
        @(posedge mclk_i) disable iff (rst_i)
        ($fell(erase_busy_o) && !$past(prot_set)) |->
            (er_len_reg == `MSM_PM_SIZE) && !prot_reg;
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase did not clear protection");

    property p_nmi;
        @(posedge mclk_i) disable iff (rst_i)
        (nmi_s3 && !nmi_s2 && rst_s2) |=> nmi_req_o ##1 !nmi_req_o;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi edge missed");

    property p_rst_prio;
        @(posedge mclk_i) disable iff (rst_i)
        !rst_s2 |=> core_reset_o && !nmi_req_o;
    endproperty
    a_rst_prio: assert property (p_rst_prio) else $error("reset did not win");

    property p_pullup;
        @(posedge mclk_i) disable iff (rst_i)
        (pddr[0] == `MSM_RST_BYTE && por[0] == `MSM_RST_BYTE) |=>
            (pullup_input_o[7:0] == `MSM_ONES_BYTE) && (port_oe_n_o[7:0] == `MSM_ONES_BYTE);
    endproperty
    a_pullup: assert property (p_pullup) else $error("port not pulled-up input");

    property p_prog;
        @(posedge mclk_i) disable iff (rst_i)
        (!rst_s2 && vpp_s2) |=> prog_mode_o;
    endproperty
    a_prog: assert property (p_prog) else $error("programming mode not entered");

    property p_call;
        @(posedge mclk_i) disable iff (rst_i)
        do_call |=> (pc_o == $past(pc_target_i)) && (stk[0] == $past(pc_plus));
    endproperty
    a_call: assert property (p_call) else $error("call push wrong");

    property p_inc;
        @(posedge mclk_i) disable iff (rst_i)
        (run && pc_inc_i && !pc_ret_i && !pc_call_i && !pc_load_i) |=>
            pc_o == $past(pc_o) + `MSM_PC_STEP;
    endproperty
    a_inc: assert property (p_inc) else $error("pc step wrong");
endmodule : msm_space_map
